// ### design/eil_params.svh
// constants of the external interrupt logic: fixed type codes, widths, timing
// assumes inclusion by bare name from every design file that needs them
`ifndef EIL_PARAMS_SVH
`define EIL_PARAMS_SVH

// width of an interrupt type code, 256 types
`define EIL_TYPE_W 8
// fixed type of the non-maskable request
`define EIL_NMI_TYPE 8'h02
// clocks in one acknowledge bus cycle
`define EIL_ACK_CLKS 4
// reset values of the two flags
`define EIL_ENABLE_RST 1'b0
`define EIL_STEP_RST 1'b0

`endif

// ### design/eil_pkg.sv
// types shared by the external interrupt logic
// assumes eil_params.svh is on the include path
`default_nettype none
`include "eil_params.svh"

package eil_pkg;
    // ****************************************
    // types
    // ****************************************
    typedef logic [`EIL_TYPE_W-1:0] eil_type_t;

    // one-hot acknowledge sequencer states
    typedef enum logic [2:0] {
        EIL_IDLE = 3'b001,
        EIL_ACK1 = 3'b010,
        EIL_ACK2 = 3'b100
    } eil_state_t;
endpackage : eil_pkg

`default_nettype wire

// ### design/eil_nmi_latch.sv
// non-maskable request edge detector and pending latch
// assumes the request line is synchronous to sys_clk
`default_nettype none

module eil_nmi_latch (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic nmiLine,
    input wire logic clearPending,
    output logic pending
);
    // ****************************************
    // edge detection and latch
    // ****************************************
    logic nmiLast;
    logic nmiEdge;

    // rising edge only; a held-high line gives one request
    assign nmiEdge = nmiLine && !nmiLast;

    // history follows the line even in reset, so a line already high at release is no edge
    always_ff @(posedge sys_clk) begin
        nmiLast <= nmiLine;
    end

    // set wins over clear so an edge in the clearing cycle is kept
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (nmiEdge) begin
            pending <= 1'b1;
        end else if (clearPending) begin
            pending <= 1'b0;
        end
    end

    nmi_latched_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        nmiEdge |=> pending) else $error("nmi edge not latched");
    nmi_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clearPending && !nmiEdge) |=> !pending) else $error("nmi latch not cleared");
endmodule : eil_nmi_latch

`default_nettype wire

// ### design/eil_core.sv
// external interrupt recognition and acknowledge sequencer of the processor
// assumes the instruction sequencer pulses instrDone or primitiveDone at boundaries,
// holds off new work while busy is high, and qualifies exec* with instrDone
`default_nettype none
`include "eil_params.svh"

module eil_core #(
    parameter int ACK_CLKS = `EIL_ACK_CLKS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic maxMode,
    input wire logic instrDone,
    input wire logic primitiveDone,
    input wire logic execSetEnable,
    input wire logic execClearEnable,
    input wire logic execReturn,
    input wire logic poppedEnable,
    input wire logic poppedStep,
    input wire logic execPrefix,
    input wire logic execSegLoad,
    input wire logic maskReq,
    input wire logic nmiLine,
    input wire logic holdReq,
    input wire eil_pkg::eil_type_t dataIn,
    output logic ackCycle,
    output logic ackSecond,
    output logic busLock,
    output logic holdAccept,
    output logic busy,
    output logic serviceStart,
    output logic serviceNmi,
    output eil_pkg::eil_type_t serviceType,
    output logic enableFlag,
    output logic stepFlag
);
    import eil_pkg::*;

    localparam int CNT_W = (ACK_CLKS > 1) ? $clog2(ACK_CLKS) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ACK_CLKS - 1);

    eil_state_t state;
    logic [CNT_W-1:0] cnt;
    logic lastClk;
    logic boundary;
    logic noInterrupt;
    logic flagChanging;
    logic canRecognise;
    logic nmiPending;
    logic takeNmi;
    logic takeMask;
    logic ackDone;
    logic next_serviceStart;
    logic maskShadow;

    // ****************************************
    // recognition
    // ****************************************
    // wait and string steps open a boundary mid-instruction
    assign boundary = instrDone || primitiveDone;
    // prefix and segment loads fuse with the next instruction
    assign noInterrupt = instrDone && (execPrefix || execSegLoad);
    // the flag this boundary's instruction changes must not be judged by its old value
    assign flagChanging = instrDone && (execSetEnable || execReturn || execClearEnable);
    assign canRecognise = (state == EIL_IDLE) && boundary && !noInterrupt;
    assign takeNmi = canRecognise && nmiPending;
    // line is not latched: sampled live, the requester keeps it up
    // the shadow only blocks step boundaries inside the following instruction, not its end
    assign takeMask = canRecognise && !nmiPending && maskReq && enableFlag
        && !(maskShadow && !instrDone) && !flagChanging;
    assign lastClk = (cnt == CNT_LAST);
    assign ackDone = (state == EIL_ACK2) && lastClk;
    assign next_serviceStart = takeNmi || ackDone;

    eil_nmi_latch u_nmi (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .nmiLine(nmiLine),
        .clearPending(takeNmi),
        .pending(nmiPending)
    );

    // shadow after set-enable or return, released when the next instruction completes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            maskShadow <= 1'b0;
        end else if (instrDone) begin
            maskShadow <= execSetEnable || execReturn;
        end
    end

    // ****************************************
    // acknowledge sequencer
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= EIL_IDLE;
        end else begin
            unique case (state)
                EIL_IDLE: begin
                    if (takeMask) begin
                        state <= EIL_ACK1;
                    end
                end
                EIL_ACK1: begin
                    if (lastClk) begin
                        state <= EIL_ACK2;
                    end
                end
                EIL_ACK2: begin
                    if (lastClk) begin
                        state <= EIL_IDLE;
                    end
                end
                default: begin
                    state <= EIL_IDLE;
                end
            endcase
        end
    end

    // clock counter inside one acknowledge cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n || state == EIL_IDLE || lastClk) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign ackCycle = (state != EIL_IDLE);
    assign ackSecond = (state == EIL_ACK2);
    assign busLock = maxMode && ackCycle;
    // grant waits out both acknowledges; also not in the cycle one starts
    assign holdAccept = holdReq && (state == EIL_IDLE) && !takeMask;
    assign busy = ackCycle || serviceStart;

    // ****************************************
    // service entry
    // ****************************************
    // dataIn is read only on the last clock of the second cycle, never the first
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            serviceStart <= 1'b0;
            serviceNmi <= 1'b0;
            serviceType <= '0;
        end else begin
            serviceStart <= next_serviceStart;
            serviceNmi <= takeNmi;
            if (takeNmi) begin
                serviceType <= `EIL_NMI_TYPE;
            end else if (ackDone) begin
                serviceType <= dataIn;
            end
        end
    end

    // flags: entry clear beats instruction updates
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enableFlag <= `EIL_ENABLE_RST;
            stepFlag <= `EIL_STEP_RST;
        end else if (next_serviceStart) begin
            enableFlag <= 1'b0;
            stepFlag <= 1'b0;
        end else if (instrDone && execReturn) begin
            enableFlag <= poppedEnable;
            stepFlag <= poppedStep;
        end else if (instrDone && execSetEnable) begin
            enableFlag <= 1'b1;
        end else if (instrDone && execClearEnable) begin
            enableFlag <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    localparam int ACK_MAX = 64;

    sequence firstAck;
        ackCycle && !ackSecond;
    endsequence
    sequence secondAck;
        ackCycle && ackSecond;
    endsequence

    ack_order_a: assert property ($rose(ackCycle) |-> firstAck ##[1:ACK_MAX] secondAck)
        else $error("acknowledge cycles out of order");
    ack_start_a: assert property ($rose(ackCycle) |-> $past(boundary))
        else $error("acknowledge started off a boundary");
    type_capture_a: assert property (ackDone |=> serviceStart && !ackCycle
        && serviceType == $past(dataIn)) else $error("type byte not captured");
    nmi_fixed_a: assert property (takeNmi |=> serviceStart && serviceNmi && !ackCycle
        && serviceType == `EIL_NMI_TYPE) else $error("nmi service wrong");
    nmi_first_a: assert property ((canRecognise && nmiPending && maskReq) |=> !ackCycle)
        else $error("maskable taken over nmi");
    mask_off_a: assert property ((state == EIL_IDLE && !enableFlag) |=> !ackCycle)
        else $error("masked request acknowledged");
    mask_take_a: assert property ((canRecognise && !nmiPending && maskReq && enableFlag
        && !(maskShadow && !instrDone) && !flagChanging) |=> ackCycle)
        else $error("request not serviced");
    shadow_hold_a: assert property ((instrDone && execSetEnable) ##1 !instrDone
        |-> !takeMask) else $error("enable took effect early");
    lock_span_a: assert property (busLock == (maxMode && ackCycle))
        else $error("lock not matching acknowledges");
    hold_defer_a: assert property (ackCycle |-> !holdAccept)
        else $error("hold granted during acknowledge");
    entry_clear_a: assert property (serviceStart |-> !enableFlag && !stepFlag)
        else $error("flags not cleared on entry");
    prefix_guard_a: assert property (noInterrupt |=> !serviceStart && !ackCycle)
        else $error("interrupt after prefix");
endmodule : eil_core

`default_nettype wire

// ### tb/eil_pic_model.sv
// behavioural model of the external interrupt controller facing eil_core
// assumes all its inputs are synchronous to sys_clk and driven just after the edge
`default_nettype none

module eil_pic_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic raise,
    input wire logic withdraw,
    input wire logic slow,
    input wire eil_pkg::eil_type_t code,
    input wire logic ackCycle,
    input wire logic ackSecond,
    output logic maskReq,
    output eil_pkg::eil_type_t dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    import eil_pkg::*;
    eil_type_t junk;
    logic inSecond;

    // request is a held level: the cpu keeps no copy, so drop only on answer or withdrawal
    always_ff @(posedge sys_clk) begin
        if (!rst_n || ackCycle || withdraw) begin
            maskReq <= 1'b0;
        end else if (raise) begin
            maskReq <= 1'b1;
        end
    end

    // idle bus pattern moves every cycle so a stale sample can never match
    always_ff @(posedge sys_clk) begin
        junk <= rst_n ? junk + 8'h5b : 8'ha5;
        inSecond <= ackSecond;
    end

    // nothing useful in the first cycle; slow answers from the second clock of the second cycle on
    assign dataIn = (ackSecond && (!slow || inSecond)) ? code : junk;
endmodule : eil_pic_model

`default_nettype wire

// ### tb/cpu_external_interrupt_logic_test.sv
// self-checking bench of eil_core with a controller model on the maskable side
// assumes eil_pkg is compiled first; the acknowledge length is shortened to 2 clocks
`default_nettype none

module cpu_external_interrupt_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    import eil_pkg::*;
    localparam int ACK = 2;
    logic sys_clk, rst_n, maxMode, instrDone, primitiveDone, execSetEnable, execClearEnable;
    logic execReturn, poppedEnable, poppedStep, execPrefix, execSegLoad, maskReq, nmiLine;
    logic holdReq, ackCycle, ackSecond, busLock, holdAccept, busy, serviceStart, serviceNmi;
    logic enableFlag, stepFlag, raise, withdraw, slow;
    eil_type_t dataIn, serviceType, code;
    int n_mismatch, n_checks;
    logic [31:0] seed;

    eil_core #(.ACK_CLKS(ACK)) i_eil_core (.sys_clk(sys_clk), .rst_n(rst_n), .maxMode(maxMode),
        .instrDone(instrDone), .primitiveDone(primitiveDone), .execSetEnable(execSetEnable),
        .execClearEnable(execClearEnable), .execReturn(execReturn),
        .poppedEnable(poppedEnable), .poppedStep(poppedStep), .execPrefix(execPrefix),
        .execSegLoad(execSegLoad), .maskReq(maskReq), .nmiLine(nmiLine), .holdReq(holdReq),
        .dataIn(dataIn), .ackCycle(ackCycle), .ackSecond(ackSecond), .busLock(busLock),
        .holdAccept(holdAccept), .busy(busy), .serviceStart(serviceStart),
        .serviceNmi(serviceNmi), .serviceType(serviceType), .enableFlag(enableFlag),
        .stepFlag(stepFlag));
    eil_pic_model i_eil_pic_model (.sys_clk(sys_clk), .rst_n(rst_n), .raise(raise),
        .withdraw(withdraw), .slow(slow), .code(code), .ackCycle(ackCycle),
        .ackSecond(ackSecond), .maskReq(maskReq), .dataIn(dataIn));

    // ****************************************
    // clock, shared tasks
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // one boundary; k = {prim, seg, prefix, return, clear, set}
    task automatic bnd(input logic [5:0] k);
        {primitiveDone, execSegLoad, execPrefix, execReturn, execClearEnable} = k[5:1];
        execSetEnable = k[0];
        instrDone = !k[5];
        tick();
        {instrDone, primitiveDone, execSegLoad, execPrefix, execReturn} = 5'h00;
        {execClearEnable, execSetEnable} = 2'h0;
    endtask : bnd

    // controller strobe: raise or withdraw the held request
    task automatic pic(input logic w);
        raise = !w;
        withdraw = w;
        tick();
        {raise, withdraw} = 2'h0;
    endtask : pic

    task automatic nmi_edge();
        nmiLine = 1'b1;
        tick();
        nmiLine = 1'b0;
    endtask : nmi_edge

    task automatic none();
        repeat (2 * ACK + 2) begin
            chk(8'(serviceStart | ackCycle), 8'h00);
            chk(8'({holdAccept, busLock}), 8'({holdReq, 1'b0}));
            tick();
        end
    endtask : none

    // follow one service from the taking edge and compare its shape
    task automatic svc(input logic nmi, input eil_type_t ty);
        int n, a, s;
        a = 0;
        s = 0;
        for (n = 1; n < 40 && serviceStart !== 1'b1; n++) begin
            a += ackCycle;
            s += ackSecond;
            chk(8'(busLock), 8'(maxMode & ackCycle));
            chk(8'(holdAccept), 8'(holdReq & !ackCycle));
            tick();
        end
        chk(8'(n), nmi ? 8'h01 : 8'(2 * ACK + 1));
        chk(8'(a), nmi ? 8'h00 : 8'(2 * ACK));
        chk(8'(s), nmi ? 8'h00 : 8'(ACK));
        chk(8'(serviceNmi), 8'(nmi));
        chk(serviceType, ty);
        chk(8'({enableFlag, stepFlag}), 8'h00);
        chk(8'(busy), 8'h01);
        tick();
        chk(8'({serviceStart, busy}), 8'h00);
    endtask : svc

    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 32'h01ebd8bf;
        {maxMode, instrDone, primitiveDone, execSetEnable, execClearEnable} = 5'h00;
        {execReturn, poppedEnable, poppedStep, execPrefix, execSegLoad} = 5'h00;
        {nmiLine, holdReq, raise, withdraw, slow} = 5'h00;
        code = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chk(8'({enableFlag, stepFlag, busy}), 8'h00);
        $display("test reset done");
        pic(1'b0);
        repeat (3) begin
            chk(8'(ackCycle), 8'h00);
            tick();
        end
        bnd(6'h00);
        none();
        $display("test masked done");
        for (int i = 0; i < 4; i++) begin
            code = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            maxMode = 1'($random(seed));
            holdReq = 1'($random(seed));
            slow = 1'(i);
            pic(1'b0);
            bnd(6'h01);
            chk(8'(enableFlag), 8'h01);
            none();
            bnd(6'h20);
            none();
            bnd(6'h00);
            svc(1'b0, code);
        end
        $display("test maskable done");
        bnd(6'h01);
        tick();
        bnd(6'h00);
        pic(1'b0);
        bnd(6'h02);
        none();
        chk(8'(enableFlag), 8'h00);
        pic(1'b1);
        {poppedEnable, poppedStep} = 2'h3;
        bnd(6'h04);
        chk(8'({enableFlag, stepFlag}), 8'h03);
        tick();
        bnd(6'h00);
        pic(1'b0);
        nmi_edge();
        bnd(6'h00);
        svc(1'b1, 8'h02);
        bnd(6'h00);
        none();
        $display("test clear return nmi done");
        nmi_edge();
        bnd(6'h08);
        none();
        bnd(6'h20);
        svc(1'b1, 8'h02);
        nmi_edge();
        bnd(6'h10);
        none();
        bnd(6'h00);
        svc(1'b1, 8'h02);
        pic(1'b1);
        $display("test prefix segment done");
        conclude();
    end
endmodule : cpu_external_interrupt_logic_test

`default_nettype wire
